// ---- hw/sdram_ctl_end.sv ----
// Controller end: power-up sequence then user commands
`timescale 1ns/1ps
module sdram_ctl_end
  import sdram_term_pkg::*;
#(
  parameter int PAUSE = PAUSE_CYCLES,
  parameter int REFS  = INIT_REFRESHES
) (
  input  wire logic              CLK,
  input  wire logic              RESET_N,
  sdram_link_if.ctl              LINK,
  input  wire logic              REQ_VALID,
  input  wire logic [2:0]        REQ_CMD,
  input  wire logic [ADDR_W-1:0] REQ_ADDR,
  input  wire logic [DATA_W-1:0] REQ_WDATA,
  output logic                   REQ_READY,
  output logic                   INIT_DONE,
  output logic [DATA_W-1:0]      RD_DATA,
  output logic                   RD_VALID
);
  typedef enum logic [4:0] {
    S_PAUSE = 5'h01, S_PRE = 5'h02, S_REF = 5'h04, S_MODE = 5'h08, S_RUN = 5'h10
  } state_t;
  state_t            state_reg;          // Init sequencer state
  logic [31:0]       cnt_reg;            // Wait counter
  logic [3:0]        refs_reg;           // Refreshes issued
  logic [CAS_LAT+1:0] rd_sh_reg;         // Read beats expected on bus
  logic              go;                 // User command accepted
  logic [3:0]        wr_left_reg;        // Write beats still to drive
  logic [3:0]        rd_left_reg;        // Read beats still to launch
  logic              rd_beat;            // A read beat is launched this cycle

  assign go = (state_reg == S_RUN) && REQ_VALID;

  // A read beat follows every read command, and the rest of its burst unless
  // a write, precharge or stop cuts it short, just as the memory does
  assign rd_beat = (go && REQ_CMD == CMD_READ) ||
                   (rd_left_reg != 4'h0 && !(go && (REQ_CMD == CMD_WRITE ||
                    REQ_CMD == CMD_PRE || REQ_CMD == CMD_STOP)));

  // Init sequence with no-op gaps, then run
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      state_reg <= S_PAUSE;
      cnt_reg   <= '0;
      refs_reg  <= 4'h0;
    end else begin
      unique case (state_reg)
        S_PAUSE: begin // R7
          cnt_reg <= cnt_reg + 32'h1;
          if (cnt_reg >= 32'(PAUSE - 1)) begin
            state_reg <= S_PRE;
            cnt_reg   <= '0;
          end
        end
        S_PRE, S_REF: begin // R8
          cnt_reg <= cnt_reg + 32'h1;
          if (cnt_reg == 32'(GAP_CYCLES)) begin
            cnt_reg <= '0;
            if (state_reg == S_REF) refs_reg <= refs_reg + 4'h1;
            if (state_reg == S_PRE || refs_reg + 4'h1 < 4'(REFS)) state_reg <= S_REF;
            else state_reg <= S_MODE;
          end
        end
        S_MODE: begin
          cnt_reg <= cnt_reg + 32'h1;
          if (cnt_reg == 32'(GAP_CYCLES)) state_reg <= S_RUN;
        end
        S_RUN: ;
      endcase
    end
  end

  // Command pins, registered; no-op unless a command is due
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      {LINK.ras_n, LINK.cas_n, LINK.we_n} <= CMD_NOP;
      LINK.cke  <= 1'b1;
      LINK.cs_n <= 1'b0;
      LINK.addr <= '0;
    end else begin
      LINK.cke <= 1'b1; // R12
      LINK.addr <= '0;
      {LINK.ras_n, LINK.cas_n, LINK.we_n} <= CMD_NOP; // R12
      if (state_reg == S_PRE && cnt_reg == 32'h0) begin
        {LINK.ras_n, LINK.cas_n, LINK.we_n} <= CMD_PRE;
        LINK.addr[ALL_BIT] <= 1'b1; // R9
      end else if (state_reg == S_REF && cnt_reg == 32'h0) begin
        {LINK.ras_n, LINK.cas_n, LINK.we_n} <= CMD_REF; // R11
      end else if (state_reg == S_MODE && cnt_reg == 32'h0) begin
        {LINK.ras_n, LINK.cas_n, LINK.we_n} <= CMD_MODE; // R10
        LINK.addr <= MODE_WORD;
      end else if (go) begin
        {LINK.ras_n, LINK.cas_n, LINK.we_n} <= REQ_CMD;
        LINK.addr <= REQ_ADDR;
      end
    end
  end

  // Data drive: one word a cycle for the whole write burst
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      LINK.dq_ctl    <= '0;
      LINK.dq_ctl_oe <= 1'b0;
      wr_left_reg    <= 4'h0;
    end else begin
      LINK.dq_ctl <= REQ_WDATA;
      if (go && REQ_CMD == CMD_WRITE) begin // R4
        LINK.dq_ctl_oe <= 1'b1;
        wr_left_reg    <= 4'(BURST_LEN - 1);
      end else if (go && (REQ_CMD == CMD_READ || REQ_CMD == CMD_PRE ||
                   REQ_CMD == CMD_STOP)) begin // R4
        // Let go at once; read data needs the latency before it reaches the bus
        LINK.dq_ctl_oe <= 1'b0;
        wr_left_reg    <= 4'h0;
      end else if (wr_left_reg != 4'h0) begin
        LINK.dq_ctl_oe <= 1'b1;
        wr_left_reg    <= wr_left_reg - 4'h1;
      end else begin
        LINK.dq_ctl_oe <= 1'b0;
      end
    end
  end

  // Track every read beat so writes wait until the bus is free
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      rd_sh_reg   <= '0;
      rd_left_reg <= 4'h0;
    end else begin
      rd_sh_reg <= {rd_sh_reg[CAS_LAT:0], rd_beat};
      if (go && REQ_CMD == CMD_READ) rd_left_reg <= 4'(BURST_LEN - 1); // R1
      else if (!rd_beat) rd_left_reg <= 4'h0;
      else rd_left_reg <= rd_left_reg - 4'h1;
    end
  end

  // Ready drops while read data may still return, keeping writes off the bus
  always_ff @(posedge CLK) begin
    if (!RESET_N) REQ_READY <= 1'b0;
    else REQ_READY <= (state_reg == S_RUN) && rd_sh_reg == '0 && !rd_beat; // R4
  end

  // Status and read return
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      INIT_DONE <= 1'b0;
      RD_DATA   <= '0;
      RD_VALID  <= 1'b0;
    end else begin
      INIT_DONE <= (state_reg == S_RUN);
      RD_DATA   <= LINK.dq;
      RD_VALID  <= rd_sh_reg[CAS_LAT];
    end
  end
endmodule // sdram_ctl_end

// ---- hw/sdram_link_if.sv ----
// Interface joining the memory controller and the memory
`timescale 1ns/1ps
interface sdram_link_if;
  import sdram_term_pkg::*;
  logic              cke;       // Clock gate enable
  logic              cs_n;      // Chip select, active low
  logic              ras_n;     // Row strobe
  logic              cas_n;     // Column strobe
  logic              we_n;      // Write strobe
  logic [ADDR_W-1:0] addr;      // Address, bank bits included
  logic [DATA_W-1:0] dq_ctl;    // Controller data out
  logic              dq_ctl_oe; // Controller drives data
  logic [DATA_W-1:0] dq_mem;    // Memory data out
  logic              dq_mem_oe; // Memory drives data
  logic [DATA_W-1:0] dq;        // Resolved wire level
  assign dq = dq_ctl_oe ? dq_ctl : (dq_mem_oe ? dq_mem : '0);
  modport ctl (output cke, cs_n, ras_n, cas_n, we_n, addr, dq_ctl, dq_ctl_oe,
               input dq);
  modport mem (input cke, cs_n, ras_n, cas_n, we_n, addr, dq_ctl, dq_ctl_oe,
               output dq_mem, dq_mem_oe, input dq);
endinterface

// ---- hw/sdram_mem_end.sv ----
// Memory end: command decode, burst engine with early termination
`timescale 1ns/1ps
module sdram_mem_end
  import sdram_term_pkg::*;
#(
  parameter int COLS = 1 << COL_W
) (
  input  wire logic              CLK,
  input  wire logic              RESET_N,
  sdram_link_if.mem              LINK,
  output logic                   BANK_A_OPEN,
  output logic                   BANK_B_OPEN,
  output logic                   MODE_SET,
  output logic [3:0]             REFRESH_COUNT,
  output logic                   BURST_ACTIVE
);
  logic [DATA_W-1:0] mem_a [COLS];              // Bank A page storage
  logic [DATA_W-1:0] mem_b [COLS];              // Bank B page storage
  logic [2:0]        cmd;                       // Decoded strobes
  logic              sel;                       // Command is valid
  logic [COL_W-1:0]  col_reg;                   // Current burst column
  logic              bank_reg;                  // Current burst bank
  logic              wr_reg;                    // Burst is a write
  logic [3:0]        left_reg;                  // Beats left in burst
  logic [CAS_LAT-1:0] rd_pipe_reg;              // Read data latency pipe
  logic [DATA_W-1:0]  rd_dat_reg [CAS_LAT];     // Read data pipe
  logic              row_b;                     // Bank bit of command

  assign cmd   = {LINK.ras_n, LINK.cas_n, LINK.we_n};
  assign sel   = !LINK.cs_n && LINK.cke;
  assign row_b = LINK.addr[BANK_BIT];

  // Bank state: open on activate, close on precharge
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      BANK_A_OPEN <= 1'b0;
      BANK_B_OPEN <= 1'b0;
    end else if (sel && cmd == CMD_ACT) begin
      if (row_b) BANK_B_OPEN <= 1'b1;
      else BANK_A_OPEN <= 1'b1;
    end else if (sel && cmd == CMD_PRE) begin // R9
      if (LINK.addr[ALL_BIT] || !row_b) BANK_A_OPEN <= 1'b0;
      if (LINK.addr[ALL_BIT] || row_b) BANK_B_OPEN <= 1'b0;
    end
  end

  // Mode set and refresh bookkeeping
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      MODE_SET      <= 1'b0;
      REFRESH_COUNT <= 4'h0;
    end else if (sel && cmd == CMD_MODE) begin // R10
      MODE_SET <= 1'b1;
    end else if (sel && cmd == CMD_REF && REFRESH_COUNT != 4'hf) begin // R11
      // Row address comes from an internal counter, row closes itself
      REFRESH_COUNT <= REFRESH_COUNT + 4'h1;
    end
  end

  // Burst engine; any column command restarts the burst
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      left_reg <= 4'h0;
      col_reg  <= '0;
      bank_reg <= 1'b0;
      wr_reg   <= 1'b0;
    end else if (sel && (cmd == CMD_READ || cmd == CMD_WRITE)) begin // R1
      left_reg <= 4'(BURST_LEN);
      col_reg  <= LINK.addr[COL_W-1:0];
      bank_reg <= row_b;
      wr_reg   <= (cmd == CMD_WRITE);
    end else if (sel && cmd == CMD_PRE) begin // R2
      left_reg <= 4'h0;
    end else if (sel && cmd == CMD_STOP) begin // R3
      // Only the burst ends; bank open flags are untouched
      left_reg <= 4'h0; // R5
    end else if (left_reg != 4'h0) begin
      left_reg <= left_reg - 4'h1;
      col_reg  <= col_reg + COL_W'(1);
    end
  end

  // Write storage; a write beat lands with its own column command too
  always_ff @(posedge CLK) begin
    if (sel && cmd == CMD_WRITE) begin
      if (row_b) mem_b[LINK.addr[COL_W-1:0]] <= LINK.dq;
      else mem_a[LINK.addr[COL_W-1:0]] <= LINK.dq;
    end else if (left_reg > 4'h1 && wr_reg && !(sel && (cmd == CMD_STOP ||
                 cmd == CMD_PRE || cmd == CMD_READ))) begin // R6
      // Beats already sampled stay stored; a stop blocks the rest
      if (bank_reg) mem_b[col_reg + COL_W'(1)] <= LINK.dq;
      else mem_a[col_reg + COL_W'(1)] <= LINK.dq;
    end
  end

  // Read data pipe, CAS latency deep
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      rd_pipe_reg <= '0;
      for (int i = 0; i < CAS_LAT; i++) rd_dat_reg[i] <= '0;
    end else begin
      rd_pipe_reg[0] <= (sel && cmd == CMD_READ) ||
                        (left_reg > 4'h1 && !wr_reg && !(sel && (cmd == CMD_STOP ||
                         cmd == CMD_PRE || cmd == CMD_WRITE)));
      rd_dat_reg[0]  <= (sel && cmd == CMD_READ) ?
                        (row_b ? mem_b[LINK.addr[COL_W-1:0]] : mem_a[LINK.addr[COL_W-1:0]]) :
                        (bank_reg ? mem_b[col_reg + COL_W'(1)] : mem_a[col_reg + COL_W'(1)]);
      for (int i = 1; i < CAS_LAT; i++) begin
        rd_pipe_reg[i] <= rd_pipe_reg[i-1];
        rd_dat_reg[i]  <= rd_dat_reg[i-1];
      end
    end
  end

  assign LINK.dq_mem    = rd_dat_reg[CAS_LAT-1];
  assign LINK.dq_mem_oe = rd_pipe_reg[CAS_LAT-1];

  // Burst activity flag for observation
  always_ff @(posedge CLK) begin
    if (!RESET_N) BURST_ACTIVE <= 1'b0;
    else BURST_ACTIVE <= (left_reg > 4'h1);
  end
endmodule // sdram_mem_end

// ---- hw/sdram_term_pkg.sv ----
// Shared constants for the burst-termination and power-up link
// Overview of operation
// R1: New read or write overrides running burst
// R2: Precharge stops burst and closes bank
// R3: Burst stop ends burst, row stays open
// R4: Controller avoids driving data against memory
// R5: Write beats after burst stop are dropped
// R6: Write beats before stop are stored
// R7: Controller waits 200 us before init commands
// R8: Precharge all, then two refreshes, before mode
// R9: Precharge decode with all-select and bank bit
// R10: Mode set is all three strobes low
// R11: Refresh is row and column low only
// R12: Controller sends no-ops during init waits
package sdram_term_pkg;
  localparam int ADDR_W           = 12;   // Address lines
  localparam int DATA_W           = 16;   // Data lines
  localparam int COL_W            = 8;    // Column bits used by the model array
  localparam int ALL_BIT          = 10;   // Precharge-all select position
  localparam int BANK_BIT         = 11;   // Bank select position
  localparam int CLK_PERIOD_PS    = 8000; // 125 MHz clock period
  localparam int PAUSE_US         = 200;  // Power-up pause
  localparam int PAUSE_CYCLES     = (PAUSE_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int INIT_REFRESHES   = 2;    // Least refresh count before mode set
  localparam int CAS_LAT          = 3;    // Read latency used by both ends
  localparam int BURST_LEN        = 8;    // Burst length used by both ends
  localparam int GAP_CYCLES       = 8;    // No-op gap between init commands
  localparam logic [ADDR_W-1:0] MODE_WORD = 12'h033; // Latency 3, length 8
  // Command encoding {ras_n, cas_n, we_n}
  typedef enum logic [2:0] {
    CMD_MODE   = 3'h0,
    CMD_REF    = 3'h1,
    CMD_PRE    = 3'h2,
    CMD_WRITE  = 3'h4,
    CMD_READ   = 3'h5,
    CMD_ACT    = 3'h3,
    CMD_STOP   = 3'h6,
    CMD_NOP    = 3'h7
  } cmd_t;
endpackage

// ---- test/sdram_link_assertions.sv ----
// Checker watching the command lines and data drive enables between both ends
`timescale 1ns/1ps
module sdram_link_assertions
  import sdram_term_pkg::*;
#(
  parameter int PAUSE = PAUSE_CYCLES
) (
  input wire logic              CLK,
  input wire logic              RESET_N,
  input wire logic              cke,
  input wire logic              cs_n,
  input wire logic              ras_n,
  input wire logic              cas_n,
  input wire logic              we_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic              dq_ctl_oe,
  input wire logic              dq_mem_oe
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  logic [2:0]  cmd;      // Strobes as one code
  logic        act;      // Anything but a no-op, chip selected
  logic [15:0] up_reg;   // Cycles since reset, saturating
  logic [3:0]  refs_reg; // Refreshes seen
  logic        pall_reg; // Precharge of both banks seen
  assign cmd = {ras_n, cas_n, we_n};
  assign act = !cs_n && cmd != CMD_NOP;
  // Saturate so a long run never wraps back into the pause
  always_ff @(posedge CLK) begin
    if (!RESET_N) up_reg <= '0;
    else if (up_reg != 16'hffff) up_reg <= up_reg + 16'h1;
  end
  // Refresh count up to the mode set
  always_ff @(posedge CLK) begin
    if (!RESET_N) refs_reg <= '0;
    else if (act && cmd == CMD_REF && refs_reg != 4'hf) refs_reg <= refs_reg + 4'h1;
  end
  // Remember the all-bank precharge
  always_ff @(posedge CLK) begin
    if (!RESET_N) pall_reg <= 1'b0;
    else if (act && cmd == CMD_PRE && addr[ALL_BIT]) pall_reg <= 1'b1;
  end
  sequence read_cmd; act && cmd == CMD_READ; endsequence
  sequence halt_cmd; act && (cmd == CMD_PRE || cmd == CMD_STOP); endsequence
  no_contention_a: assert property (!(dq_ctl_oe && dq_mem_oe))
    else $error("both ends drive data");
  pause_kept_a: assert property (act |-> int'(up_reg) >= PAUSE - 1)
    else $error("command inside power-up pause");
  refresh_after_pall_a: assert property (act && cmd == CMD_REF |-> pall_reg)
    else $error("refresh before precharge all");
  mode_after_refs_a: assert property (act && cmd == CMD_MODE |-> refs_reg >= INIT_REFRESHES)
    else $error("mode set with too few refreshes");
  mode_word_a: assert property (act && cmd == CMD_MODE |-> addr == MODE_WORD)
    else $error("mode word wrong");
  clock_gate_a: assert property (cke)
    else $error("clock gate low");
  init_gap_a: assert property (act && cmd == CMD_REF |=> (!act)[*2])
    else $error("no gap after refresh");
  read_data_a: assert property (read_cmd |-> ##3 dq_mem_oe)
    else $error("read data late");
  halt_burst_a: assert property (halt_cmd |-> ##3 !dq_mem_oe)
    else $error("burst runs on after halt");
  first_pre_all_a: assert property (act && cmd == CMD_PRE && refs_reg == 4'h0 |-> addr[ALL_BIT])
    else $error("init precharge not all banks");
endmodule // sdram_link_assertions

// ---- test/testbench.sv ----
// Self-checking bench for both ends joined across the link
`timescale 1ns/1ps
module testbench;
  import sdram_term_pkg::*;
  localparam int PAUSE = 20;            // Short pause keeps the run brief
  logic        CLK       = 1'b0;        // 125 MHz clock
  logic        RESET_N   = 1'b0;        // Held low at start
  logic        valid     = 1'b0;        // User request strobe
  logic [2:0]  cmd       = CMD_NOP;     // User command code
  logic [11:0] addr      = '0;          // User address
  logic [15:0] wdata     = '0;          // User write word
  logic        ready, init_done, rd_valid, a_open, b_open, mode_set, bursting;
  logic [15:0] rd_data;                 // Read beat
  logic [3:0]  refs;                    // Refreshes seen by memory
  logic [15:0] rq[$];                   // Collected read beats
  int          miscompares = 0;         // Mismatch count
  int          n_checks    = 0;         // Comparison count
  sdram_link_if i_sdram_link_if ();
  sdram_ctl_end #(.PAUSE(PAUSE), .REFS(INIT_REFRESHES)) i_sdram_ctl_end (.CLK(CLK),
    .RESET_N(RESET_N), .LINK(i_sdram_link_if), .REQ_VALID(valid), .REQ_CMD(cmd),
    .REQ_ADDR(addr), .REQ_WDATA(wdata), .REQ_READY(ready), .INIT_DONE(init_done),
    .RD_DATA(rd_data), .RD_VALID(rd_valid));
  sdram_mem_end i_sdram_mem_end (.CLK(CLK), .RESET_N(RESET_N), .LINK(i_sdram_link_if),
    .BANK_A_OPEN(a_open), .BANK_B_OPEN(b_open), .MODE_SET(mode_set),
    .REFRESH_COUNT(refs), .BURST_ACTIVE(bursting));
  sdram_link_assertions #(.PAUSE(PAUSE)) i_sdram_link_assertions (.CLK(CLK),
    .RESET_N(RESET_N), .cke(i_sdram_link_if.cke), .cs_n(i_sdram_link_if.cs_n),
    .ras_n(i_sdram_link_if.ras_n), .cas_n(i_sdram_link_if.cas_n),
    .we_n(i_sdram_link_if.we_n), .addr(i_sdram_link_if.addr),
    .dq_ctl_oe(i_sdram_link_if.dq_ctl_oe), .dq_mem_oe(i_sdram_link_if.dq_mem_oe));
  // Clock: invert every half period
  always #4 CLK = ~CLK;
  // Gather every read beat in arrival order
  always @(posedge CLK) if (rd_valid === 1'b1) rq.push_back(rd_data);
  // Compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  // Report counts, give the verdict, stop
  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Bounded wait for the controller to accept requests; look once outputs settle
  task automatic wait_ready();
    int n;
    n = 0;
    #1;
    while (ready !== 1'b1 && n < 100) begin
      @(posedge CLK);
      #1;
      n++;
    end
    if (ready !== 1'b1) begin
      miscompares++;
      give_verdict();
    end
  endtask
  // One request held for a single taking edge, once the controller is ready
  task automatic send(input logic [2:0] c, input logic [11:0] a);
    wait_ready();
    send_now(c, a);
  endtask
  // Same without waiting; only for commands that never drive data
  task automatic send_now(input logic [2:0] c, input logic [11:0] a);
    @(posedge CLK);
    valid <= 1'b1;
    cmd <= c;
    addr <= a;
    @(posedge CLK);
    valid <= 1'b0;
  endtask
  // Write burst of eight words; a stop may replace beat stop_at
  task automatic wr(input logic [7:0] col, input logic [15:0] base, input int stop_at);
    wait_ready();
    for (int i = 0; i < BURST_LEN; i++) begin
      @(posedge CLK);
      valid <= (i == 0 || i == stop_at);
      cmd <= (i == 0) ? CMD_WRITE : CMD_STOP;
      addr <= {4'h0, col};
      wdata <= base + 16'(i);
    end
    @(posedge CLK);
    valid <= 1'b0;
  endtask
  // Let read beats land; latency and length are fixed
  task automatic settle();
    repeat (CAS_LAT + BURST_LEN + 4) @(posedge CLK);
  endtask
  // Main sequence
  initial begin
    repeat (20) @(posedge CLK);
    RESET_N <= 1'b1;
    for (int n = 0; n < 400 && init_done !== 1'b1; n++) @(posedge CLK);
    if (init_done !== 1'b1) begin
      miscompares++;
      give_verdict();
    end
    check(init_done, 1'b1);
    check(mode_set, 1'b1);
    check(refs, 4'(INIT_REFRESHES));
    send(CMD_ACT, 12'h001);
    wr(8'h10, 16'h1100, 99);
    wr(8'h20, 16'h2200, 99);
    wr(8'h20, 16'h3300, 3);
    check(a_open, 1'b1);
    rq.delete();
    send(CMD_READ, 12'h020);
    repeat (3) @(posedge CLK);
    check(ready, 1'b0);
    check(bursting, 1'b1);
    settle();
    check(16'(rq.size()), 16'h8);
    foreach (rq[i]) check(rq[i], (i < 3 ? 16'h3300 : 16'h2200) + 16'(i));
    rq.delete();
    send(CMD_READ, 12'h020);
    send_now(CMD_READ, 12'h010);
    settle();
    check(16'((rq.size() > 8) && (rq.size() < 16)), 16'h1);
    for (int i = 0; i < 8; i++) check(rq[rq.size() - 8 + i], 16'h1100 + 16'(i));
    rq.delete();
    send(CMD_READ, 12'h010);
    send_now(CMD_PRE, 12'h000);
    settle();
    check(16'(rq.size() < 8), 16'h1);
    check(a_open, 1'b0);
    check(bursting, 1'b0);
    send(CMD_ACT, 12'h801);
    send(CMD_ACT, 12'h001);
    repeat (3) @(posedge CLK);
    check({a_open, b_open}, 2'h3);
    send(CMD_PRE, 12'h400);
    repeat (3) @(posedge CLK);
    check({a_open, b_open}, 2'h0);
    give_verdict();
  end
endmodule // testbench
